// *** gpb_pkg.sv ***
// Shared constants for the three-bank general-purpose pin block.
package gpb_pkg;

	// Pins served by one bank and number of banks with pin logic.
	localparam int GPB_PINS = 16;
	localparam int GPB_BANKS = 3;
	// Bus widths of the register port.
	localparam int GPB_AW = 8;
	localparam int GPB_DW = 32;
	// Bank index of the fourth port, which only has a function select.
	localparam logic [1:0] GPB_BANK_J = 2'h3;
	// Register offsets inside one bank; the bank index is in address bits 7:6.
	localparam logic [5:0] GPB_OFF_DATA = 6'h00;
	localparam logic [5:0] GPB_OFF_CLEAR = 6'h04;
	localparam logic [5:0] GPB_OFF_SET = 6'h08;
	localparam logic [5:0] GPB_OFF_TOGGLE = 6'h0C;
	localparam logic [5:0] GPB_OFF_MASKA_CLR = 6'h10;
	localparam logic [5:0] GPB_OFF_MASKA_SET = 6'h14;
	localparam logic [5:0] GPB_OFF_MASKB_CLR = 6'h18;
	localparam logic [5:0] GPB_OFF_MASKB_SET = 6'h1C;
	localparam logic [5:0] GPB_OFF_DIR = 6'h20;
	localparam logic [5:0] GPB_OFF_SENS = 6'h24;
	localparam logic [5:0] GPB_OFF_BOTH = 6'h28;
	localparam logic [5:0] GPB_OFF_INEN = 6'h2C;
	localparam logic [5:0] GPB_OFF_STATUS = 6'h30;
	localparam logic [5:0] GPB_OFF_FSEL = 6'h34;
	// Value of every control register after reset.
	localparam logic [15:0] GPB_RST = 16'h0000;

endpackage

// *** gpb_sync.sv ***
`timescale 1ns/100ps
// Two-flop synchroniser for a vector of asynchronous pin levels.
module gpb_sync
#(
	parameter int W = 16
)
(
	input wire logic clock,
	input wire logic reset,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	import gpb_pkg::*;

	// First stage; only the second stage reads it.
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	// Next values simply shift the pin level along the chain.
	always_comb
	begin
		meta_nxt = d;
		q_nxt = meta_r;
	end

	// Both stages hold while the clock enable is low.
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			meta_r <= '0;
			q <= '0;
		end
		else if (ce)
		begin
			meta_r <= meta_nxt;
			q <= q_nxt;
		end
	end

endmodule

// *** gpb_irq.sv ***
`timescale 1ns/100ps
// Per-pin interrupt condition: level pass-through or latched edge.
module gpb_irq
#(
	parameter int W = 16
)
(
	input wire logic clock,
	input wire logic reset,
	input wire logic ce,
	input wire logic [W-1:0] src,
	input wire logic [W-1:0] sens,
	input wire logic [W-1:0] both,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] flag
);
	import gpb_pkg::*;

	// Previous source level, for edge detection.
	logic [W-1:0] src_d_r;
	// Sticky edge flags.
	logic [W-1:0] lat_r;
	logic [W-1:0] lat_nxt;
	logic [W-1:0] edge_ev;

	// A rising edge always counts; a falling edge only where both edges are chosen.
	always_comb
	begin
		edge_ev = (src & ~src_d_r) | (both & ~src & src_d_r);
		// The set term is applied after the clear so a same-cycle event is kept.
		lat_nxt = ((lat_r & ~clr) | edge_ev) & sens;
		// Level pins follow the source; edge pins show the latch.
		flag = (sens & lat_r) | (~sens & src);
	end

	// Registers hold while the clock enable is low.
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			src_d_r <= '0;
			lat_r <= '0;
		end
		else if (ce)
		begin
			src_d_r <= src;
			lat_r <= lat_nxt;
		end
	end

endmodule

// *** gpb_top.sv ***
`timescale 1ns/100ps
module gpb_top
#(
	parameter int PINS = gpb_pkg::GPB_PINS,
	parameter int BANKS = gpb_pkg::GPB_BANKS
)
(
	input wire logic clock,
	input wire logic reset,
	input wire logic ce,
	input wire logic [gpb_pkg::GPB_AW-1:0] addr,
	input wire logic [gpb_pkg::GPB_DW-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [gpb_pkg::GPB_DW-1:0] rdata,
	input wire logic [BANKS*PINS-1:0] pin_in,
	output wire logic [BANKS*PINS-1:0] pin_out,
	output wire logic [BANKS*PINS-1:0] pin_oe,
	output wire logic [BANKS*PINS-1:0] pin_ie,
	input wire logic [BANKS*PINS-1:0] periph_out,
	input wire logic [BANKS*PINS-1:0] periph_oe,
	output wire logic [BANKS*PINS-1:0] periph_in,
	output logic [PINS-1:0] port_j_fsel,
	output wire logic [BANKS-1:0] irq_a,
	output wire logic [BANKS-1:0] irq_b
);
	import gpb_pkg::*;

	// Address split: bank index on top, register offset below.
	logic [1:0] bank_sel;
	logic [5:0] reg_off;
	// Write data cut to the width of one bank.
	logic [PINS-1:0] wbits;
	// Read value that each bank offers for the current address.
	logic [PINS-1:0] bank_rd [BANKS];
	// Read data next value.
	logic [GPB_DW-1:0] rdata_nxt;
	// Fourth port function select next value.
	logic [PINS-1:0] port_j_fsel_nxt;

	assign bank_sel = addr[7:6];
	assign reg_off = addr[5:0];
	assign wbits = wdata[PINS-1:0];

	genvar b;
	generate
		for (b = 0; b < BANKS; b++)
		begin : g_bank
			// Output latch, direction, interrupt masks and sensitivity controls.
			logic [PINS-1:0] data_r, data_nxt;
			logic [PINS-1:0] dir_r, dir_nxt;
			logic [PINS-1:0] mska_r, mska_nxt;
			logic [PINS-1:0] mskb_r, mskb_nxt;
			logic [PINS-1:0] sens_r, sens_nxt;
			logic [PINS-1:0] both_r, both_nxt;
			// Input buffer enable per pin.
			logic [PINS-1:0] inen_r, inen_nxt;
			// A one hands the pin to the multiplexed peripheral.
			logic [PINS-1:0] fsel_r, fsel_nxt;
			// Registered pin drive, so the pads see no decode glitches.
			logic [PINS-1:0] pout_r, pout_nxt;
			logic [PINS-1:0] poe_r, poe_nxt;
			logic [PINS-1:0] pie_r, pie_nxt;
			// Registered interrupt requests.
			logic irqa_r, irqa_nxt;
			logic irqb_r, irqb_nxt;
			// Synchronised pin levels, gated levels and interrupt sources.
			logic [PINS-1:0] pin_sync;
			logic [PINS-1:0] sensed;
			logic [PINS-1:0] irq_src;
			logic [PINS-1:0] irq_flag;
			logic [PINS-1:0] edge_clr;
			logic wr_hit;

			assign wr_hit = wr && (bank_sel == 2'(b));

			// Pins are asynchronous, so nothing reads them before two flops.
			gpb_sync #(.W(PINS)) u_sync (
				.clock(clock),
				.reset(reset),
				.ce(ce),
				.d(pin_in[b*PINS +: PINS]),
				.q(pin_sync)
			);

			// Register writes: each modify register touches only the ones written.
			always_comb
			begin
				data_nxt = data_r;
				dir_nxt = dir_r;
				mska_nxt = mska_r;
				mskb_nxt = mskb_r;
				sens_nxt = sens_r;
				both_nxt = both_r;
				inen_nxt = inen_r;
				fsel_nxt = fsel_r;
				edge_clr = '0;
				if (wr_hit)
				begin
					case (reg_off)
						GPB_OFF_DATA:
						begin
							data_nxt = wbits;
						end
						GPB_OFF_CLEAR:
						begin
							// Clearing also acknowledges latched edges on those pins.
							data_nxt = data_r & ~wbits;
							edge_clr = wbits;
						end
						GPB_OFF_SET:
						begin
							data_nxt = data_r | wbits;
						end
						GPB_OFF_TOGGLE:
						begin
							data_nxt = data_r ^ wbits;
						end
						GPB_OFF_MASKA_CLR:
						begin
							mska_nxt = mska_r & ~wbits;
						end
						GPB_OFF_MASKA_SET:
						begin
							mska_nxt = mska_r | wbits;
						end
						GPB_OFF_MASKB_CLR:
						begin
							mskb_nxt = mskb_r & ~wbits;
						end
						GPB_OFF_MASKB_SET:
						begin
							mskb_nxt = mskb_r | wbits;
						end
						GPB_OFF_DIR:
						begin
							dir_nxt = wbits;
						end
						GPB_OFF_SENS:
						begin
							sens_nxt = wbits;
						end
						GPB_OFF_BOTH:
						begin
							both_nxt = wbits;
						end
						GPB_OFF_INEN:
						begin
							inen_nxt = wbits;
						end
						GPB_OFF_FSEL:
						begin
							fsel_nxt = wbits;
						end
						default:
						begin
							// Unmapped and read-only offsets ignore writes.
						end
					endcase
				end
			end

			// Pin-side values: the peripheral wins where it owns the pin.
			always_comb
			begin
				// An input buffer that is off reads as zero.
				sensed = pin_sync & inen_r;
				// Outputs raise interrupts from what software wrote to them.
				irq_src = (dir_r & data_r) | (~dir_r & sensed);
				pout_nxt = (fsel_r & periph_out[b*PINS +: PINS]) | (~fsel_r & data_r);
				poe_nxt = (fsel_r & periph_oe[b*PINS +: PINS]) | (~fsel_r & dir_r);
				// Peripherals always see their pins; GPIO only when enabled.
				pie_nxt = fsel_r | inen_r;
				irqa_nxt = |(irq_flag & mska_r);
				irqb_nxt = |(irq_flag & mskb_r);
			end

			// Level or edge detection per pin.
			gpb_irq #(.W(PINS)) u_irq (
				.clock(clock),
				.reset(reset),
				.ce(ce),
				.src(irq_src),
				.sens(sens_r),
				.both(both_r),
				.clr(edge_clr),
				.flag(irq_flag)
			);

			// Read value of this bank at the current offset.
			always_comb
			begin
				case (reg_off)
					GPB_OFF_DATA: bank_rd[b] = data_r;
					GPB_OFF_MASKA_SET: bank_rd[b] = mska_r;
					GPB_OFF_MASKA_CLR: bank_rd[b] = mska_r;
					GPB_OFF_MASKB_SET: bank_rd[b] = mskb_r;
					GPB_OFF_MASKB_CLR: bank_rd[b] = mskb_r;
					GPB_OFF_DIR: bank_rd[b] = dir_r;
					GPB_OFF_SENS: bank_rd[b] = sens_r;
					GPB_OFF_BOTH: bank_rd[b] = both_r;
					GPB_OFF_INEN: bank_rd[b] = inen_r;
					GPB_OFF_STATUS: bank_rd[b] = sensed;
					GPB_OFF_FSEL: bank_rd[b] = fsel_r;
					default: bank_rd[b] = '0;
				endcase
			end

			// Reset selects GPIO, input, level, masked, drivers and buffers off.
			always_ff @(posedge clock or posedge reset)
			begin
				if (reset)
				begin
					data_r <= GPB_RST;
					dir_r <= GPB_RST;
					mska_r <= GPB_RST;
					mskb_r <= GPB_RST;
					sens_r <= GPB_RST;
					both_r <= GPB_RST;
					inen_r <= GPB_RST;
					fsel_r <= GPB_RST;
					pout_r <= GPB_RST;
					poe_r <= GPB_RST;
					pie_r <= GPB_RST;
					irqa_r <= 1'b0;
					irqb_r <= 1'b0;
				end
				else if (ce)
				begin
					data_r <= data_nxt;
					dir_r <= dir_nxt;
					mska_r <= mska_nxt;
					mskb_r <= mskb_nxt;
					sens_r <= sens_nxt;
					both_r <= both_nxt;
					inen_r <= inen_nxt;
					fsel_r <= fsel_nxt;
					pout_r <= pout_nxt;
					poe_r <= poe_nxt;
					pie_r <= pie_nxt;
					irqa_r <= irqa_nxt;
					irqb_r <= irqb_nxt;
				end
			end

			// Ports are wired straight from the bank flops.
			assign pin_out[b*PINS +: PINS] = pout_r;
			assign pin_oe[b*PINS +: PINS] = poe_r;
			assign pin_ie[b*PINS +: PINS] = pie_r;
			assign periph_in[b*PINS +: PINS] = pin_sync;
			assign irq_a[b] = irqa_r;
			assign irq_b[b] = irqb_r;
		end
	endgenerate

	// The fourth port has no pin logic, only its multiplexer control.
	always_comb
	begin
		port_j_fsel_nxt = port_j_fsel;
		if (wr && (bank_sel == GPB_BANK_J) && (reg_off == GPB_OFF_FSEL))
		begin
			port_j_fsel_nxt = wbits;
		end
	end

	// Read path: data appear in the cycle after the strobe and are zero otherwise.
	always_comb
	begin
		rdata_nxt = '0;
		if (rd)
		begin
			if (bank_sel == GPB_BANK_J)
			begin
				// Only the function select answers in the fourth port.
				if (reg_off == GPB_OFF_FSEL)
				begin
					rdata_nxt = {{(GPB_DW-PINS){1'b0}}, port_j_fsel};
				end
			end
			else
			begin
				rdata_nxt = {{(GPB_DW-PINS){1'b0}}, bank_rd[bank_sel]};
			end
		end
	end

	// Top-level registers; all freeze while the clock enable is low.
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			rdata <= '0;
			port_j_fsel <= GPB_RST;
		end
		else if (ce)
		begin
			rdata <= rdata_nxt;
			port_j_fsel <= port_j_fsel_nxt;
		end
	end

endmodule

// *** gpb_top_props.sv ***
`timescale 1ns/100ps
// Port checks of the pin block.
module gpb_top_props
#(
	parameter int PINS = 16,
	parameter int BANKS = 3
)
(
	input wire logic clock,
	input wire logic reset,
	input wire logic ce,
	input wire logic [gpb_pkg::GPB_AW-1:0] addr,
	input wire logic [gpb_pkg::GPB_DW-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [gpb_pkg::GPB_DW-1:0] rdata,
	input wire logic [BANKS*PINS-1:0] pin_in,
	input wire logic [BANKS*PINS-1:0] pin_out,
	input wire logic [BANKS*PINS-1:0] pin_oe,
	input wire logic [BANKS*PINS-1:0] pin_ie,
	input wire logic [BANKS*PINS-1:0] periph_in,
	input wire logic [PINS-1:0] port_j_fsel,
	input wire logic [BANKS-1:0] irq_a,
	input wire logic [BANKS-1:0] irq_b
);
	import gpb_pkg::*;
	// High once a write was taken.
	logic cfg_r;
	logic cfg_nxt;
	// Enabled edges since reset, saturating at three, so the sync check skips reset history.
	logic [1:0] up_r;
	logic [1:0] up_nxt;
	always_comb
	begin
		cfg_nxt = cfg_r | (ce & wr);
		up_nxt = (ce && up_r != 2'h3) ? up_r + 2'h1 : up_r;
	end
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			cfg_r <= 1'b0;
			up_r <= 2'h0;
		end
		else
		begin
			cfg_r <= cfg_nxt;
			up_r <= up_nxt;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	sequence s_fsel_wr;
		ce && wr && addr == 8'hF4;
	endsequence
	a_reset_quiet: assert property (disable iff (1'b0) reset |-> (pin_oe | pin_ie | pin_out) == '0)
		else $error("outputs busy in reset");
	a_idle_off: assert property (!cfg_r |-> pin_oe == '0 && pin_ie == '0)
		else $error("pin on before setup");
	a_gpio_default: assert property (!cfg_r |-> pin_out == '0)
		else $error("peripheral owns pin");
	a_irq_masked: assert property (!cfg_r |-> irq_a == '0 && irq_b == '0)
		else $error("request before setup");
	a_fsel_load: assert property (s_fsel_wr |=> port_j_fsel == $past(wdata[15:0]))
		else $error("select not loaded");
	a_fsel_hold: assert property (!(ce && wr && addr == 8'hF4) |=> $stable(port_j_fsel))
		else $error("select moved");
	a_rdata_idle: assert property (ce && !rd |=> rdata == '0)
		else $error("read data not idle");
	a_hole_zero: assert property (ce && rd && addr[5:0] == 6'h38 |=> rdata == '0)
		else $error("hole read not zero");
	a_sync_two: assert property (up_r == 2'h3 && $past(ce) && $past(ce, 2) |-> periph_in == $past(pin_in, 2))
		else $error("sync depth wrong");
	a_hold_frozen: assert property (!ce |=> $stable(pin_out) && $stable(pin_oe) && $stable(irq_a))
		else $error("moved while frozen");
endmodule
bind gpb_top gpb_top_props #(.PINS(PINS), .BANKS(BANKS)) i_gpb_top_props (.clock, .reset, .ce, .addr,
	.wdata, .wr, .rd, .rdata, .pin_in, .pin_out, .pin_oe, .pin_ie, .periph_in, .port_j_fsel, .irq_a, .irq_b);

// *** gpb_pin_model.sv ***
`timescale 1ns/100ps
// Outside world: a pin follows the block when driven, else the bench where ext_en is set.
module gpb_pin_model
(
	input wire logic clock,
	input wire logic [47:0] pin_out,
	input wire logic [47:0] pin_oe,
	input wire logic [47:0] ext_val,
	input wire logic [47:0] ext_en,
	output logic [47:0] pin_in
);
	// Undriven pins flip each cycle, so stale levels never pass.
	bit [47:0] float_r;
	always_ff @(posedge clock)
		float_r <= ~float_r;
	always_comb
		pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | (~ext_en & float_r)));
endmodule

// *** test_gpb_top.sv ***
`timescale 1ns/100ps
// Register model predicts reads, pins and request lines.
module test_gpb_top;
	import gpb_pkg::*;
	logic clock, reset, ce, wr, rd;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [47:0] pin_in, pin_out, pin_oe, pin_ie, p_out, p_oe, p_in, ext_val;
	logic [15:0] jsel;
	logic [2:0] irq_a, irq_b;
	int error_cnt, tests_run, mr [4][16];
	int cyc = 0;
	// Random write offsets, with status and a hole.
	logic [5:0] op [12] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h2C, 6'h30, 6'h38};
	gpb_top i_gpb_top (.clock, .reset, .ce, .addr, .wdata, .wr, .rd, .rdata, .pin_in, .pin_out, .pin_oe,
		.pin_ie, .periph_out(p_out), .periph_oe(p_oe), .periph_in(p_in), .port_j_fsel(jsel), .irq_a, .irq_b);
	gpb_pin_model i_gpb_pin_model (.clock, .pin_out, .pin_oe, .ext_val, .ext_en(48'hFFFF_FFFF_FFFF), .pin_in);
	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task automatic tally_and_finish();
		$display("Compared %0d, mismatched %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// A hang counts as a mismatch.
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask
	// Slots: 0 data, 3 mask A, 5 mask B, 8 dir, 11 inen, 13 select.
	function automatic void m_wr(input int b, input int o, input int v);
		if (b == 3 && o != 52)
			return;
		case (o)
			0: mr[b][0] = v;
			4: mr[b][0] &= ~v;
			8: mr[b][0] |= v;
			12: mr[b][0] ^= v;
			16, 24: mr[b][o/4-1] &= ~v;
			20, 28: mr[b][o/4-2] |= v;
			default: if (o != 48 && o < 56) mr[b][o/4] = v;
		endcase
	endfunction
	function automatic int m_rd(input int b, input int o);
		int lv;
		if (b == 3)
			return (o == 52) ? mr[3][13] : 0;
		lv = (mr[b][8] & mr[b][0]) | (~mr[b][8] & ext_val[b*16+:16]);
		case (o)
			0: return mr[b][0];
			16, 20: return mr[b][3];
			24, 28: return mr[b][5];
			48: return mr[b][11] & lv;
			32, 36, 40, 44, 52: return mr[b][o/4];
			default: return 0;
		endcase
	endfunction
	// Level mode: outputs raise from data, inputs from sensed pins.
	function automatic logic [5:0] m_irq();
		logic [5:0] r;
		int s;
		for (int b = 0; b < 3; b++)
		begin
			s = (mr[b][8] & mr[b][0]) | (~mr[b][8] & m_rd(b, 48));
			r[b] = |(s & mr[b][3]);
			r[b+3] = |(s & mr[b][5]);
		end
		return r;
	endfunction
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
		@(posedge clock);
		addr <= a;
		wdata <= {16'h0000, v};
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		if (ce)
			m_wr(a[7:6], a[5:0], v);
	endtask
	task automatic rd_chk(input logic [7:0] a);
		int e;
		e = m_rd(a[7:6], a[5:0]);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 chk(rdata, e[15:0]);
	endtask
	task automatic estep(input logic v, input logic e);
		@(posedge clock);
		ext_val[16] <= v;
		repeat (6) @(posedge clock);
		#1 chk({irq_b[1], irq_a[1]}, {1'b0, e});
	endtask
	initial
	begin
		// Every input gets its own idle value, so no field is left unknown.
		reset = 1'b0;
		ce = 1'b1;
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
		p_out = '0;
		p_oe = '0;
		ext_val = '0;
		{error_cnt, tests_run} = 0;
		mr = '{default: 0};
		void'($urandom(86));
		// Reset rises on a clock edge, so no flop can miss its edge at time zero.
		@(posedge clock);
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		repeat (3) @(posedge clock);
		#1 chk(pin_oe | pin_ie | pin_out, '0);
		for (int o = 0; o < 64; o += 4)
			if (o < 4 || o > 12) rd_chk({2'h0, o[5:0]});
		repeat (2)
		begin
			for (int k = 0; k < 48; k++)
				wr_reg({k[5:4], op[k % 12]}, 16'($urandom));
			@(posedge clock);
			ext_val <= 48'({$urandom, $urandom});
			repeat (6) @(posedge clock);
			for (int k = 0; k < 48; k++)
				if (k % 16 < 1 || k % 16 > 3) rd_chk({k[5:4], k[3:0], 2'h0});
			chk(pin_oe, {mr[2][8][15:0], mr[1][8][15:0], mr[0][8][15:0]});
			chk(pin_out, {mr[2][0][15:0], mr[1][0][15:0], mr[0][0][15:0]});
			chk(pin_ie, {mr[2][11][15:0], mr[1][11][15:0], mr[0][11][15:0]});
			chk({irq_b, irq_a}, m_irq());
		end
		// A write while the clock enable is low must be dropped.
		@(posedge clock);
		ce <= 1'b0;
		wr_reg(8'h00, 16'hA5A5);
		ce <= 1'b1;
		rd_chk(8'h00);
		// Bank 1 is cleaned up first: only pin 0 is an enabled input, unmasked on line A alone.
		wr_reg(8'h50, 16'hFFFF);
		wr_reg(8'h58, 16'hFFFF);
		wr_reg(8'h60, 16'h0000);
		wr_reg(8'h6C, 16'h0001);
		wr_reg(8'h54, 16'h0001);
		// A level request follows the pin both ways.
		estep(1, 1);
		estep(0, 0);
		// Edge mode, rising only: the latch holds through the fall until cleared.
		wr_reg(8'h64, 16'h0001);
		estep(1, 1);
		estep(0, 1);
		wr_reg(8'h44, 16'h0001);
		estep(0, 0);
		// Both edges: a falling edge alone must set the latch again.
		wr_reg(8'h68, 16'h0001);
		estep(1, 1);
		wr_reg(8'h44, 16'h0001);
		estep(0, 1);
		wr_reg(8'h44, 16'h0001);
		estep(0, 0);
		// An output pin requests from its written value, whatever the far side shows.
		wr_reg(8'h64, 16'h0000);
		wr_reg(8'h60, 16'h0001);
		wr_reg(8'h48, 16'h0001);
		estep(0, 1);
		// Hand bank 0 to the peripheral side.
		wr_reg(8'h34, 16'hFFFF);
		@(posedge clock);
		{p_oe, p_out} <= 96'({$urandom, $urandom, $urandom});
		repeat (3) @(posedge clock);
		#1 chk({pin_oe[15:0], pin_out[15:0]}, {p_oe[15:0], p_out[15:0]});
		chk(pin_ie[15:0], 16'hFFFF);
		wr_reg(8'hF4, 16'h5A3C);
		rd_chk(8'hF4);
		rd_chk(8'hC0);
		chk(jsel, 16'h5A3C);
		chk($bits(pin_in), 48);
		tally_and_finish();
	end
endmodule
